// File: dv/mpcfm_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("Error %s exp %h got %h", n, e, g); end end
module mpcfm_bench;
  import mpcfm_pkg::*;
  logic                clk_in, nrst_in, ext_clk, comp;
  mpcfm_apb_req_type   req;
  mpcfm_apb_rsp_type   rsp;
  mpcfm_gen_type       gen;
  mpcfm_fault_src_type flt;
  logic [5:0]          pwm;
  logic                rld, tick, ldv, fault, run;
  logic [7:0]          v, m [int];
  int                  num_errors, n_checks, shoot, cnt, gap, last;
  int                  pos [4] = '{0, 1, 2, 5};
  mpcfm_top dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .apb_in(req), .apb_out(rsp), .gen_in(gen),
    .external_pwm_clock_in(ext_clk), .fault_src_in(flt), .pwm_out(pwm), .reload_event_out(rld),
    .pwm_tick_out(tick), .load_values_out(ldv), .counter_run_out(run), .fault_out(fault));
  mpcfm_gate_model gate_u (.clk_in(clk_in), .cmp_in(comp), .gate_in(pwm), .shoot_out(shoot));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Pin is noise unless selected as source
  always @(posedge clk_in) ext_clk <= 1'($urandom);
  task automatic apb(input logic w, input logic [11:0] i, input logic [7:0] d, output logic [7:0] q,
                     output logic e);
    int t;
    t = 0;
    @(posedge clk_in);
    req <= '{1'b1, 1'b0, w, {2'b00, i, 2'b00}, {24'h0, d}};
    @(posedge clk_in);
    req.penable <= 1'b1;
    do @(posedge clk_in); while (rsp.pready !== 1'b1 && ++t < 20);
    if (rsp.pready !== 1'b1) num_errors++;
    q = rsp.prdata[7:0];
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    logic [7:0] q;
    logic       e, r;
    r = m[12'hf20][0];
    apb(1'b1, i, d, q, e);
    if (i == 12'hf24) d &= 8'h27;
    if (i == 12'hf20) d &= 8'heb;
    if (i == 12'hf21 && r) d[5] = m[i][5];
    if (m.exists(i) && !(r && i inside {12'hf22, 12'hf23, 12'hf24})) m[i] = d;
  endtask : wr
  task automatic rd(input logic [11:0] i);
    logic [7:0] q;
    logic       e;
    apb(1'b0, i, 8'h00, q, e);
    `CHK("slverr", 1'(!m.exists(i)), e)
    `CHK("read", m.exists(i) ? m[i] : 8'h00, q)
  endtask : rd
  task automatic pulse;
    gen.period_end <= 1'b1;
    @(posedge clk_in);
    gen.period_end <= 1'b0;
    #1;
  endtask : pulse
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial begin
    {nrst_in, ext_clk, comp, req, gen, flt} = '0;
    m[12'hf20] = 8'h00;
    m[12'hf21] = 8'h00;
    m[12'hf22] = 8'h01;
    m[12'hf23] = 8'h00;
    m[12'hf24] = 8'h00;
    void'($urandom(32'h9430));
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    foreach (m[i]) rd(12'(i));
    rd(12'hf2f);
    wr(12'hf24, 8'h27);
    rd(12'hf24);
    v = 8'($urandom) & 8'hdf;
    wr(12'hf21, v);
    rd(12'hf21);
    repeat (3) @(posedge clk_in);
    #1;
    `CHK("off state", {{2{v[4]}}, {2{v[3]}}, {2{v[2]}}}, pwm)
    $display("regs done");
    for (int s = 0; s < 4; s++) begin
      v = 8'($urandom) & 8'h27;
      wr(12'hf24, v);
      flt <= mpcfm_fault_src_type'(4'b0001 << s);
      repeat (6) @(posedge clk_in);
      `CHK("fault", !v[pos[s]], fault)
      flt <= '0;
      repeat (6) @(posedge clk_in);
    end
    $display("faults done");
    for (int r = 0; r < 4; r++) begin
      wr(12'hf20, 8'h00);
      wr(12'hf21, 8'(r << 6));
      wr(12'hf20, 8'h01);
      last = -1;
      gap = 0;
      for (int k = 0; k < 24; k++) begin
        pulse();
        if (rld === 1'b1 && last >= 0) gap = k - last;
        if (rld === 1'b1) last = k;
        @(posedge clk_in);
      end
      `CHK("reload gap", 1 << r, gap)
    end
    wr(12'hf20, 8'h00);
    wr(12'hf21, 8'h02);
    wr(12'hf20, 8'h03);
    // Old rate of eight holds for the first period end only; the second reloads at the new rate of one
    pulse();
    @(posedge clk_in);
    pulse();
    `CHK("load", 1'b1, ldv)
    m[12'hf20] = 8'h01;
    cnt = 0;
    repeat (32) begin
      @(posedge clk_in);
      #1 cnt += tick;
    end
    `CHK("ticks", 8, cnt)
    $display("reload done");
    wr(12'hf20, 8'h00);
    wr(12'hf22, 8'h05);
    wr(12'hf23, 8'h01);
    gen.level <= 6'h00;
    comp <= 1'b1;
    wr(12'hf20, 8'h01);
    repeat (20) @(posedge clk_in);
    gen.level <= 6'h01;
    cnt = 0;
    repeat (30) begin
      @(posedge clk_in);
      #1 cnt += (pwm[1:0] == 2'b00);
    end
    `CHK("dead time", 5, cnt)
    `CHK("shoot", 0, shoot)
    comp <= 1'b0;
    wr(12'hf20, 8'h00);
    wr(12'hf21, 8'h20);
    wr(12'hf20, 8'h01);
    wr(12'hf21, 8'h00);
    rd(12'hf21);
    wr(12'hf22, 8'h09);
    rd(12'hf22);
    v = 8'($urandom);
    gen.level <= v[5:0];
    repeat (40) @(posedge clk_in);
    #1;
    `CHK("independent", v[5:0], pwm)
    `CHK("run on", 1'b1, run)
    wr(12'hf20, 8'h00);
    repeat (3) @(posedge clk_in);
    #1;
    `CHK("stopped", 6'h00, pwm)
    `CHK("run off", 1'b0, run)
    $display("outputs done");
    give_verdict();
  end
  initial begin
    #200us;
    num_errors++;
    give_verdict();
  end
endmodule : mpcfm_bench
`default_nettype wire

// File: dv/mpcfm_gate_model.sv
`timescale 1ns/100ps
`default_nettype none
module mpcfm_gate_model (
  // Drive side
  input  wire logic       clk_in,
  input  wire logic       cmp_in,
  input  wire logic [5:0] gate_in,
  // Health
  output var  int         shoot_out
);
  // Both switches of one leg on would short the rail
  initial shoot_out = 0;
  always @(posedge clk_in)
    if (cmp_in && |(gate_in[4:0] & gate_in[5:1] & 5'h15)) shoot_out <= shoot_out + 1;
endmodule : mpcfm_gate_model
`default_nettype wire

// File: dv/mpcfm_props.sv
`timescale 1ns/100ps
`default_nettype none
module mpcfm_props (
  // Clock and reset
  input wire logic                          clk_in,
  input wire logic                          nrst_in,
  // Bus, generator and fault sources
  input wire mpcfm_pkg::mpcfm_apb_req_type   apb_in,
  input wire mpcfm_pkg::mpcfm_apb_rsp_type   apb_out,
  input wire mpcfm_pkg::mpcfm_gen_type       gen_in,
  input wire mpcfm_pkg::mpcfm_fault_src_type fault_src_in,
  // Results
  input wire logic                          reload_event_out,
  input wire logic                          load_values_out,
  input wire logic                          counter_run_out,
  input wire logic                          fault_out
);
  import mpcfm_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Periods since last reload; a stuck divider pushes it past eight
  logic [3:0] pe_cnt_reg;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) pe_cnt_reg <= 4'h0;
    else if (reload_event_out || !counter_run_out) pe_cnt_reg <= 4'h0;
    else if (gen_in.period_end) pe_cnt_reg <= pe_cnt_reg + 4'h1;
  end
  pready_a: assert property (apb_in.psel && apb_in.penable |-> apb_out.pready)
    else $error("pready low in access");
  slverr_a: assert property (apb_out.pslverr |-> apb_in.psel && apb_in.penable)
    else $error("pslverr outside access");
  rdata_a: assert property (apb_out.pready && !apb_in.pwrite |-> apb_out.prdata[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  reload_cause_a: assert property (reload_event_out |-> $past(gen_in.period_end) && $past(counter_run_out))
    else $error("reload without period end");
  group_limit_a: assert property (pe_cnt_reg <= 4'h8)
    else $error("more than eight periods without reload");
  load_reload_a: assert property (load_values_out |-> reload_event_out)
    else $error("load outside reload");
  stop_quiet_a: assert property ((!counter_run_out) [*2] |-> !reload_event_out)
    else $error("reload while stopped");
  fault_quiet_a: assert property ((fault_src_in == '0) [*4] |=> !fault_out)
    else $error("fault with no source");
  cover property (load_values_out);
  cover property (reload_event_out ##[2:20] reload_event_out);
  cover property (fault_out);
endmodule : mpcfm_props
bind mpcfm_top mpcfm_props props_u (.clk_in, .nrst_in, .apb_in, .apb_out, .gen_in, .fault_src_in,
  .reload_event_out, .load_values_out, .counter_run_out, .fault_out);
`default_nettype wire

// File: verilog/mpcfm_cfg.svh
`ifndef MPCFM_CFG_SVH
`define MPCFM_CFG_SVH
// Register indices; byte address is index times four
`define MPCFM_CTRL_FIRST_IDX  12'hf20
`define MPCFM_CTRL_SECOND_IDX 12'hf21
`define MPCFM_DEAD_TIME_IDX   12'hf22
`define MPCFM_MIN_PULSE_IDX   12'hf23
`define MPCFM_FAULT_MASK_IDX  12'hf24
`define MPCFM_FAULT_STAT_IDX  12'hf25
`define MPCFM_CLK_SRC_IDX     12'hf26
// Reset values
`define MPCFM_CTRL_FIRST_RST  8'h00
`define MPCFM_CTRL_SECOND_RST 8'h00
`define MPCFM_DEAD_TIME_RST   8'h01
`define MPCFM_MIN_PULSE_RST   8'h00
`define MPCFM_FAULT_MASK_RST  8'h00
// Write masks for reserved bits
`define MPCFM_CTRL_FIRST_WMASK 8'heb
`define MPCFM_FAULT_MASK_WMASK 8'h27
`define MPCFM_FAULT_STAT_WMASK 8'ha7
// Field positions
`define MPCFM_RUN_BIT     0
`define MPCFM_READY_BIT   1
`define MPCFM_INDEP_BIT   5
`define MPCFM_RELOAD_FLAG 7
`endif

// File: verilog/mpcfm_pkg.sv
package mpcfm_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } mpcfm_apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } mpcfm_apb_rsp_type;
  typedef struct packed {
    logic        period_end;
    logic [5:0]  level;
  } mpcfm_gen_type;
  typedef struct packed {
    logic        debug_entry;
    logic        second_fault;
    logic        comparator;
    logic        primary_fault;
  } mpcfm_fault_src_type;
endpackage : mpcfm_pkg

// File: verilog/mpcfm_top.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "mpcfm_cfg.svh"
module mpcfm_top (
  // Clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          nrst_in,
  // Register bus
  input  wire mpcfm_pkg::mpcfm_apb_req_type  apb_in,
  output var  mpcfm_pkg::mpcfm_apb_rsp_type  apb_out,
  // Counter and compare side
  input  wire mpcfm_pkg::mpcfm_gen_type      gen_in,
  // Pins
  input  wire logic                          external_pwm_clock_in,
  input  wire mpcfm_pkg::mpcfm_fault_src_type fault_src_in,
  // Results
  output logic [5:0]                         pwm_out,
  output logic                               reload_event_out,
  output logic                               pwm_tick_out,
  output logic                               load_values_out,
  output logic                               counter_run_out,
  output logic                               fault_out
);
  import mpcfm_pkg::*;

  typedef struct packed {
    logic [7:0]      ctrl_first;
    logic [7:0]      ctrl_second;
    logic [7:0]      dead_time;
    logic [7:0]      min_pulse;
    logic [7:0]      fault_mask;
    logic [7:0]      fault_stat;
    logic            clk_src;
    logic [1:0]      rate_work;
    logic [1:0]      clock_divider_select_work;
    logic [2:0]      period_cnt;
    logic [2:0]      div_cnt;
    logic [4:0]      sync1;
    logic [4:0]      sync2;
    logic            ext_prev;
    logic [5:0]      filt;
    logic [5:0][7:0] hold_cnt;
    logic [2:0]      pair_last;
    logic [2:0][7:0] dead_cnt;
    logic [5:0]      pwm;
    logic            reload;
    logic            tick;
    logic            load;
    logic            fault;
    logic [7:0]      rdata;
    logic            err;
  } mpcfm_state_type;

  mpcfm_state_type state_reg;
  mpcfm_state_type state_next;

  logic [13:0] word_idx;
  logic        acc_cycle;
  logic        wr_now;
  logic        setup_now;
  logic        run;
  logic        indep;
  logic [2:0]  pol;
  logic        ext_edge;
  logic        src_edge;
  logic [2:0]  div_max;
  logic [2:0]  rate_max;
  logic        reload_now;
  logic [3:0]  src_lvl;
  logic [3:0]  src_mask;
  logic [3:0]  src_act;
  logic [7:0]  wd;
  logic        hit;
  logic [7:0]  rd;
  logic        act;
  logic [7:0]  flag_set;
  logic [7:0]  flag_busy;

  assign word_idx  = apb_in.paddr[15:2];
  assign acc_cycle = apb_in.psel & apb_in.penable;
  assign wr_now    = acc_cycle & apb_in.pwrite;
  assign setup_now = apb_in.psel & ~apb_in.penable;
  assign wd        = apb_in.pwdata[7:0];
  assign run       = state_reg.ctrl_first[`MPCFM_RUN_BIT];
  assign indep     = state_reg.ctrl_second[`MPCFM_INDEP_BIT];
  assign pol       = state_reg.ctrl_second[4:2];

  always_comb begin
    state_next = state_reg;
    act        = 1'b0;
    hit        = 1'b1;
    rd         = 8'h00;
    state_next.reload = 1'b0;
    state_next.tick   = 1'b0;
    state_next.load   = 1'b0;

    // Pins are asynchronous, two stages before use
    state_next.sync1    = {external_pwm_clock_in, fault_src_in};
    state_next.sync2    = state_reg.sync1;
    state_next.ext_prev = state_reg.sync2[4];
    ext_edge = state_reg.sync2[4] & ~state_reg.ext_prev;
    src_edge = state_reg.clk_src ? ext_edge : 1'b1;

    // Divider terminal counts 0, 1, 3, 7
    div_max  = {&state_reg.clock_divider_select_work, state_reg.clock_divider_select_work[1], |state_reg.clock_divider_select_work};
    rate_max = {&state_reg.rate_work, state_reg.rate_work[1], |state_reg.rate_work};

    // Prescaler
    if (!run) begin
      state_next.div_cnt = 3'h0;
    end else if (src_edge) begin
      if (state_reg.div_cnt == div_max) begin
        state_next.div_cnt = 3'h0;
        state_next.tick    = 1'b1;
      end else begin
        state_next.div_cnt = state_reg.div_cnt + 3'h1;
      end
    end

    // Reload divider over PWM periods
    reload_now = 1'b0;
    if (!run) begin
      state_next.period_cnt = 3'h0;
    end else if (gen_in.period_end) begin
      state_next.rate_work = state_reg.ctrl_second[7:6];
      // At or past the end, so a smaller new rate cannot let the count run past it
      if (state_reg.period_cnt >= rate_max) begin
        state_next.period_cnt = 3'h0;
        reload_now = 1'b1;
      end else begin
        state_next.period_cnt = state_reg.period_cnt + 3'h1;
      end
    end
    state_next.reload = reload_now;
    if (reload_now && state_reg.ctrl_first[`MPCFM_READY_BIT]) begin
      state_next.clock_divider_select_work = state_reg.ctrl_second[1:0];
      state_next.load      = 1'b1;
      state_next.ctrl_first[`MPCFM_READY_BIT] = 1'b0;
    end

    // Fault sources after masking
    src_lvl  = state_reg.sync2[3:0];
    src_mask = {state_reg.fault_mask[5], state_reg.fault_mask[2:0]};
    src_act  = src_lvl & ~src_mask;
    state_next.fault = |src_act;
    flag_set  = {reload_now, 1'b0, src_act[3], 2'b00, src_act[2:0]};
    flag_busy = {1'b0, 1'b0, src_lvl[3], 2'b00, src_lvl[2:0]};

    // Register writes, taken in the access cycle
    if (wr_now) begin
      case (word_idx)
        {2'b00, `MPCFM_CTRL_FIRST_IDX}: begin
          state_next.ctrl_first = wd & `MPCFM_CTRL_FIRST_WMASK;
        end
        {2'b00, `MPCFM_CTRL_SECOND_IDX}: begin
          state_next.ctrl_second = wd;
          if (run) begin
            state_next.ctrl_second[`MPCFM_INDEP_BIT] = state_reg.ctrl_second[`MPCFM_INDEP_BIT];
          end
        end
        {2'b00, `MPCFM_DEAD_TIME_IDX}: begin
          if (!run) begin
            state_next.dead_time = wd;
          end
        end
        {2'b00, `MPCFM_MIN_PULSE_IDX}: begin
          if (!run) begin
            state_next.min_pulse = wd;
          end
        end
        {2'b00, `MPCFM_FAULT_MASK_IDX}: begin
          if (!run) begin
            state_next.fault_mask = wd & `MPCFM_FAULT_MASK_WMASK;
          end
        end
        {2'b00, `MPCFM_FAULT_STAT_IDX}: begin
          // A flag whose source still stands cannot be cleared
          state_next.fault_stat = state_reg.fault_stat & ~(wd & ~flag_busy);
        end
        {2'b00, `MPCFM_CLK_SRC_IDX}: begin
          state_next.clk_src = wd[0];
        end
        default: begin
          state_next.clk_src = state_reg.clk_src;
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    state_next.fault_stat = (state_next.fault_stat | flag_set) & `MPCFM_FAULT_STAT_WMASK;

    // Read data captured in the setup cycle
    case (word_idx)
      {2'b00, `MPCFM_CTRL_FIRST_IDX}:  rd = state_reg.ctrl_first;
      {2'b00, `MPCFM_CTRL_SECOND_IDX}: rd = state_reg.ctrl_second;
      {2'b00, `MPCFM_DEAD_TIME_IDX}:   rd = state_reg.dead_time;
      {2'b00, `MPCFM_MIN_PULSE_IDX}:   rd = state_reg.min_pulse;
      {2'b00, `MPCFM_FAULT_MASK_IDX}:  rd = state_reg.fault_mask;
      {2'b00, `MPCFM_FAULT_STAT_IDX}:  rd = state_reg.fault_stat;
      {2'b00, `MPCFM_CLK_SRC_IDX}:     rd = {7'h00, state_reg.clk_src};
      default: begin
        rd  = 8'h00;
        hit = 1'b0;
      end
    endcase
    if (setup_now) begin
      state_next.rdata = rd;
      state_next.err   = ~hit;
    end

    // Minimum pulse filter, counted in prescaled ticks
    for (int i = 0; i < 6; i++) begin
      if (!run) begin
        state_next.filt[i]     = 1'b0;
        state_next.hold_cnt[i] = 8'h00;
      end else if (gen_in.level[i] != state_reg.filt[i] &&
                   state_reg.hold_cnt[i] >= state_reg.min_pulse) begin
        state_next.filt[i]     = gen_in.level[i];
        state_next.hold_cnt[i] = 8'h00;
      end else if (state_reg.tick && state_reg.hold_cnt[i] != 8'hff) begin
        state_next.hold_cnt[i] = state_reg.hold_cnt[i] + 8'h01;
      end
    end

    // Dead time per pair, counted in system clocks
    for (int p = 0; p < 3; p++) begin
      if (!run) begin
        state_next.pair_last[p] = 1'b0;
        state_next.dead_cnt[p]  = 8'h00;
      end else if (state_reg.filt[2*p] != state_reg.pair_last[p]) begin
        state_next.pair_last[p] = state_reg.filt[2*p];
        state_next.dead_cnt[p]  = state_reg.dead_time;
      end else if (state_reg.dead_cnt[p] != 8'h00) begin
        state_next.dead_cnt[p]  = state_reg.dead_cnt[p] - 8'h01;
      end
    end

    // Output stage; off-state is the deasserted level after polarity
    for (int i = 0; i < 6; i++) begin
      if (indep) begin
        act = state_reg.filt[i];
      end else begin
        act = ((i % 2 == 0) ? state_reg.pair_last[i/2] : ~state_reg.pair_last[i/2]) &
              (state_reg.dead_cnt[i/2] == 8'h00);
      end
      if (run && !state_reg.fault) begin
        state_next.pwm[i] = act ^ pol[i/2];
      end else begin
        state_next.pwm[i] = pol[i/2];
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg             <= '0;
      state_reg.ctrl_first  <= `MPCFM_CTRL_FIRST_RST;
      state_reg.ctrl_second <= `MPCFM_CTRL_SECOND_RST;
      state_reg.dead_time   <= `MPCFM_DEAD_TIME_RST;
      state_reg.min_pulse   <= `MPCFM_MIN_PULSE_RST;
      state_reg.fault_mask  <= `MPCFM_FAULT_MASK_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Zero wait states; read data already held from setup
  assign apb_out.pready  = acc_cycle;
  assign apb_out.pslverr = acc_cycle & state_reg.err;
  assign apb_out.prdata  = {24'h000000, state_reg.rdata};

  assign pwm_out          = state_reg.pwm;
  assign reload_event_out = state_reg.reload;
  assign pwm_tick_out     = state_reg.tick;
  assign load_values_out  = state_reg.load;
  assign counter_run_out  = run;
  assign fault_out        = state_reg.fault;
endmodule : mpcfm_top
`default_nettype wire
